// ===== hdl/gdp_data_ports.sv
`timescale 1ns/1ps
`default_nettype none
// data side of three general-purpose pin ports
module gdp_data_ports (
   input  wire logic                          clock,
   input  wire logic                          reset_n,
   // register port
   input  wire logic [gdp_pkg::ADDR_W-1:0]    regAddr,
   input  wire logic [gdp_pkg::DATA_W-1:0]    regWrData,
   input  wire logic                          regWrite,
   input  wire logic                          regRead,
   output var  logic [gdp_pkg::DATA_W-1:0]    regRdData,
   // pin codes from the pin function controller
   input  wire logic [gdp_pkg::CODE_W-1:0]    portDFuncCode,
   input  wire logic [gdp_pkg::CODE_W-1:0]    portEFuncCode,
   input  wire logic [gdp_pkg::F_CODE_W-1:0]  portFFuncCode,
   // port D pins
   input  wire logic [gdp_pkg::DATA_W-1:0]    portDPinIn,
   output var  logic [gdp_pkg::DATA_W-1:0]    portDPinOut,
   output var  logic [gdp_pkg::DATA_W-1:0]    portDPinOe,
   output var  logic [gdp_pkg::DATA_W-1:0]    portDPullUp,
   // port E pins
   input  wire logic [gdp_pkg::DATA_W-1:0]    portEPinIn,
   output var  logic [gdp_pkg::DATA_W-1:0]    portEPinOut,
   output var  logic [gdp_pkg::DATA_W-1:0]    portEPinOe,
   output var  logic [gdp_pkg::DATA_W-1:0]    portEPullUp,
   // port F pins
   input  wire logic [gdp_pkg::F_PINS-1:0]    portFPinIn,
   output var  logic [gdp_pkg::F_PINS-1:0]    portFPinOut,
   output var  logic [gdp_pkg::F_PINS-1:0]    portFPinOe,
   output var  logic [gdp_pkg::F_PINS-1:0]    portFPullUp
);
   import gdp_pkg::*;

   // ---- functions

   // per-pin match of a packed code vector against one code
   function automatic logic [DATA_W-1:0] codeMask(
      input logic [CODE_W-1:0] codes,
      input logic [1:0]        match
   );
      logic [DATA_W-1:0] mask;
      mask = '0;
      for (int i = 0; i < DATA_W; i++) begin
         mask[i] = (codes[2*i +: 2] == match); // [R4]
      end
      return mask;
   endfunction

   // pins whose code selects a general input, either pull-up setting
   function automatic logic [DATA_W-1:0] inputMask(
      input logic [CODE_W-1:0] codes
   );
      return codeMask(codes, FUNC_IN_PU) | codeMask(codes, FUNC_IN_NOPU);
   endfunction

   // value returned for a read of one port
   function automatic logic [DATA_W-1:0] readValue(
      input logic [CODE_W-1:0] codes,
      input logic [DATA_W-1:0] stored,
      input logic [DATA_W-1:0] pins
   );
      logic [DATA_W-1:0] inMask;
      inMask = inputMask(codes);
      // stored bit for output and other function, pin for input
      return (stored & ~inMask) | (pins & inMask); // [R5] [R6] [R7]
   endfunction

   // ---- internal signals

   logic [DATA_W-1:0]   syncD;       // synced port D levels
   logic [DATA_W-1:0]   syncE;       // synced port E levels
   logic [F_PINS-1:0]   syncF;       // synced port F levels
   logic [CODE_W-1:0]   codesF;      // port F codes widened to eight pins
   logic [DATA_W-1:0]   pinsF;       // port F levels widened to eight pins
   logic [DATA_W-1:0]   next_rdData; // read data for the next cycle
   logic [DATA_W-1:0]   oeMaskF;     // port F drive mask on eight pins
   logic [DATA_W-1:0]   puMaskF;     // port F pull-up mask on eight pins

   // one store channel per port
   gdp_store_if storeD ();
   gdp_store_if storeE ();
   gdp_store_if storeF ();

   // ---- pin level synchronisers

   gdp_pin_sync #(.WIDTH(DATA_W)) u_sync_d (
      .clock     (clock),
      .reset_n   (reset_n),
      .pinLevel  (portDPinIn),
      .syncLevel (syncD)
   );

   gdp_pin_sync #(.WIDTH(DATA_W)) u_sync_e (
      .clock     (clock),
      .reset_n   (reset_n),
      .pinLevel  (portEPinIn),
      .syncLevel (syncE)
   );

   gdp_pin_sync #(.WIDTH(F_PINS)) u_sync_f (
      .clock     (clock),
      .reset_n   (reset_n),
      .pinLevel  (portFPinIn),
      .syncLevel (syncF)
   );

   // ---- stored data bits

   // port D: eight stored bits
   gdp_port_store #(
      .WIDTH       (DATA_W),
      .RESET_VALUE (RST_PORT_D)
   ) u_store_d (
      .clock   (clock),
      .reset_n (reset_n),
      .bus     (storeD.store)
   ); // [R1]

   // port E: eight stored bits
   gdp_port_store #(
      .WIDTH       (DATA_W),
      .RESET_VALUE (RST_PORT_E)
   ) u_store_e (
      .clock   (clock),
      .reset_n (reset_n),
      .bus     (storeE.store)
   ); // [R2]

   // port F: seven stored bits, top bit reserved
   gdp_port_store #(
      .WIDTH       (F_PINS),
      .RESET_VALUE (RST_PORT_F)
   ) u_store_f (
      .clock   (clock),
      .reset_n (reset_n),
      .bus     (storeF.store)
   ); // [R3]

   // ---- write decode

   // a write stores the bit whatever the pin code says
   assign storeD.wrEn   = regWrite && (regAddr == OFF_PORT_D);
   assign storeE.wrEn   = regWrite && (regAddr == OFF_PORT_E);
   assign storeF.wrEn   = regWrite && (regAddr == OFF_PORT_F);
   assign storeD.wrData = regWrData;
   assign storeE.wrData = regWrData;
   assign storeF.wrData = regWrData; // bit 7 dropped by the store [R15]

   // ---- read path

   // port F padded: reserved pin code selects stored bit, which is zero
   assign codesF = {FUNC_OTHER, portFFuncCode};
   assign pinsF  = {1'b0, syncF};
   // port F masks over the padded codes, cut to seven pins where used
   assign oeMaskF = codeMask(codesF, FUNC_OUTPUT);
   assign puMaskF = codeMask(codesF, FUNC_IN_PU);

   // read mux; unmapped offsets return zero
   always_comb begin
      next_rdData = RD_IDLE;
      if (regRead) begin
         case (regAddr)
            OFF_PORT_D: begin
               next_rdData = readValue(portDFuncCode, storeD.storedBits, syncD);
            end
            OFF_PORT_E: begin
               next_rdData = readValue(portEFuncCode, storeE.storedBits, syncE);
            end
            OFF_PORT_F: begin
               next_rdData = readValue(codesF, storeF.storedBits, pinsF); // [R3]
            end
            default: begin
               next_rdData = RD_IDLE;
            end
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= RD_IDLE;
      end else begin
         regRdData <= next_rdData;
      end
   end

   // ---- pin drive

   // driven level is the stored bit itself
   assign portDPinOut = storeD.storedBits;         // [R8]
   assign portEPinOut = storeE.storedBits;         // [R8]
   assign portFPinOut = storeF.storedBits[F_PINS-1:0]; // [R8]

   // port D enables: drive only in general output mode
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         portDPinOe <= RST_OE;
      end else begin
         portDPinOe <= codeMask(portDFuncCode, FUNC_OUTPUT); // [R8] [R9]
      end
   end

   // port E enables
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         portEPinOe <= RST_OE;
      end else begin
         portEPinOe <= codeMask(portEFuncCode, FUNC_OUTPUT); // [R8] [R9]
      end
   end

   // port F enables
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         portFPinOe <= RST_OE[F_PINS-1:0];
      end else begin
         portFPinOe <= oeMaskF[F_PINS-1:0]; // [R8] [R9]
      end
   end

   // ---- pull-ups

   // port D pull-ups; start on, as pins wake as pulled-up inputs
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         portDPullUp <= RST_PULLUP;
      end else begin
         portDPullUp <= codeMask(portDFuncCode, FUNC_IN_PU); // [R14]
      end
   end

   // port E pull-ups
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         portEPullUp <= RST_PULLUP; // [R11]
      end else begin
         portEPullUp <= codeMask(portEFuncCode, FUNC_IN_PU); // [R14]
      end
   end

   // port F pull-ups
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         portFPullUp <= RST_PULLUP[F_PINS-1:0]; // [R12]
      end else begin
         portFPullUp <= puMaskF[F_PINS-1:0]; // [R14]
      end
   end

   // ---- checks

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   // port D write reaches the pin a cycle later
   AST_D_WRITE: assert property ( // [R1]
      regWrite && regAddr == OFF_PORT_D |=> portDPinOut == $past(regWrData)
   ) else $error("port D write not stored");

   // port E write reaches the pin a cycle later
   AST_E_WRITE: assert property ( // [R2]
      regWrite && regAddr == OFF_PORT_E |=> portEPinOut == $past(regWrData)
   ) else $error("port E write not stored");

   // port F keeps the low seven bits of a write
   AST_F_WRITE: assert property ( // [R3]
      regWrite && regAddr == OFF_PORT_F
      |=> portFPinOut == $past(regWrData[F_PINS-1:0])
   ) else $error("port F write not stored");

   // port F top bit always reads zero
   AST_F_RSVD: assert property ( // [R15]
      regRead && regAddr == OFF_PORT_F |=> regRdData[F_RSVD_BIT] == 1'b0
   ) else $error("port F reserved bit read nonzero");

   // output pin reads its stored bit
   AST_RD_OUTPUT: assert property ( // [R5]
      regRead && regAddr == OFF_PORT_D && portDFuncCode[1:0] == FUNC_OUTPUT
      |=> regRdData[0] == portDPinOut[0]
   ) else $error("output pin read did not return stored bit");

   // other-function pin reads its stored bit
   AST_RD_OTHER: assert property ( // [R7]
      regRead && regAddr == OFF_PORT_E && portEFuncCode[1:0] == FUNC_OTHER
      |=> regRdData[0] == portEPinOut[0]
   ) else $error("other-function pin read did not return stored bit");

   // input pin reads its synced level
   AST_RD_INPUT: assert property ( // [R6]
      regRead && regAddr == OFF_PORT_E && portEFuncCode[1]
      |=> regRdData[0] == $past(syncE[0])
   ) else $error("input pin read did not return pin level");

   // enable follows output code one cycle later
   AST_OE_CODE: assert property ( // [R8]
      $past(reset_n) |-> portDPinOe[0] == ($past(portDFuncCode[1:0]) == FUNC_OUTPUT)
   ) else $error("pin drive enable wrong for code");

   // pull-up follows the pulled-up input code
   AST_PULLUP: assert property ( // [R14]
      $past(reset_n) |-> portEPullUp[0] == ($past(portEFuncCode[1:0]) == FUNC_IN_PU)
   ) else $error("pull-up enable wrong for code");

   // port D bits hold without a write
   AST_HOLD: assert property ( // [R13]
      !(regWrite && regAddr == OFF_PORT_D) |=> $stable(portDPinOut)
   ) else $error("port D bits changed without write");

   // port E bits hold without a write
   AST_E_HOLD: assert property ( // [R13]
      !(regWrite && regAddr == OFF_PORT_E) |=> $stable(portEPinOut)
   ) else $error("port E bits changed without write");

   // port F bits hold without a write
   AST_F_HOLD: assert property ( // [R13]
      !(regWrite && regAddr == OFF_PORT_F) |=> $stable(portFPinOut)
   ) else $error("port F bits changed without write");

   // port F enable follows output code, outside the first cycle after reset
   AST_F_OE: assert property ( // [R8]
      $past(reset_n) |-> portFPinOe[0] == ($past(portFFuncCode[1:0]) == FUNC_OUTPUT)
   ) else $error("port F drive enable wrong for code");

   // port D pull-up follows the pulled-up input code
   AST_D_PULLUP: assert property ( // [R14]
      $past(reset_n) |-> portDPullUp[0] == ($past(portDFuncCode[1:0]) == FUNC_IN_PU)
   ) else $error("port D pull-up enable wrong for code");

   // port D input pin reads its synced level
   AST_RD_D_INPUT: assert property ( // [R6]
      regRead && regAddr == OFF_PORT_D && portDFuncCode[1]
      |=> regRdData[0] == $past(syncD[0])
   ) else $error("port D input read did not return pin level");

   // port F output pin reads its stored bit
   AST_RD_F_OUTPUT: assert property ( // [R5]
      regRead && regAddr == OFF_PORT_F && portFFuncCode[1:0] == FUNC_OUTPUT
      |=> regRdData[0] == portFPinOut[0]
   ) else $error("port F output read did not return stored bit");

   // read data zero outside the answer cycle
   AST_RD_IDLE: assert property (
      !regRead |=> regRdData == RD_IDLE
   ) else $error("read data not idle");
endmodule // gdp_data_ports
`default_nettype wire

// ===== hdl/gdp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for asynchronous pin levels
module gdp_pin_sync #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] pinLevel,
   output var  logic [WIDTH-1:0] syncLevel
);
   logic [WIDTH-1:0] metaLevel; // first stage, read by second only

   // both stages clear at power-on
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         metaLevel <= '0;
         syncLevel <= '0;
      end else begin
         metaLevel <= pinLevel;
         syncLevel <= metaLevel;
      end
   end
endmodule // gdp_pin_sync
`default_nettype wire

// ===== hdl/gdp_port_store.sv
`timescale 1ns/1ps
`default_nettype none
// stored data bits of one port; unused upper bits read zero
module gdp_port_store #(
   parameter int unsigned WIDTH       = 8,
   parameter logic [7:0]  RESET_VALUE = 8'h00
) (
   input  wire logic clock,
   input  wire logic reset_n,
   gdp_store_if.store bus
);
   genvar i;
   // one flop per implemented pin
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         if (i < WIDTH) begin : g_used
            logic storedBit; // stored level of this pin
            // cleared by power-on reset only; loaded by a write, holds through anything else
            always_ff @(posedge clock or negedge reset_n) begin
               if (!reset_n) begin
                  storedBit <= RESET_VALUE[i]; // [R10] [R11] [R13]
               end else if (bus.wrEn) begin
                  storedBit <= bus.wrData[i]; // [R9]
               end
            end
            // each bit of the shared vector has one continuous driver
            assign bus.storedBits[i] = storedBit;
         end else begin : g_rsvd
            // reserved bit: no storage, writes dropped
            assign bus.storedBits[i] = 1'b0; // [R15]
         end
      end
   endgenerate
endmodule // gdp_port_store
`default_nettype wire

// ===== inc/gdp_pkg.sv
// How it works
// [R1] port D: eight stored bits, one per pin
// [R2] port E: eight stored bits, one per pin
// [R3] port F: bits 6..0 stored, bit 7 reads zero
// [R4] two-bit pin code selects function per pin
// [R5] output pins read back the stored bit
// [R6] input pins read back the synced level
// [R7] other-function pins read back the stored bit
// [R8] output pins drive the stored bit out
// [R9] non-output pins store writes without driving
// [R10] port D stored bits clear at power-on
// [R11] port E clears; pins start pulled-up inputs
// [R12] port F pins start pulled-up inputs
// [R13] only power-on reset clears stored bits
// [R14] per-pin pull-up follows the pin code
// [R15] port F bit 7 ignores writes, reads zero
`default_nettype none
package gdp_pkg;
   // bus widths
   localparam int unsigned ADDR_W   = 4;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned CODE_W   = 2 * DATA_W;
   localparam int unsigned F_PINS   = 7;
   localparam int unsigned F_CODE_W = 2 * F_PINS;
   // register offsets
   localparam logic [ADDR_W-1:0] OFF_PORT_D = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_PORT_E = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_PORT_F = 4'h2;
   // pin function codes
   localparam logic [1:0] FUNC_OTHER   = 2'h0;
   localparam logic [1:0] FUNC_OUTPUT  = 2'h1;
   localparam logic [1:0] FUNC_IN_PU   = 2'h2;
   localparam logic [1:0] FUNC_IN_NOPU = 2'h3;
   // field position of the reserved port F bit
   localparam int unsigned F_RSVD_BIT = 7;
   // reset values
   localparam logic [DATA_W-1:0] RST_PORT_D = 8'h00;
   localparam logic [DATA_W-1:0] RST_PORT_E = 8'h00;
   localparam logic [DATA_W-1:0] RST_PORT_F = 8'h00;
   localparam logic [DATA_W-1:0] RST_PULLUP = 8'hFF;
   localparam logic [DATA_W-1:0] RST_OE     = 8'h00;
   localparam logic [DATA_W-1:0] RD_IDLE    = 8'h00;
   // synchroniser depth for pin levels
   localparam int unsigned SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ===== inc/gdp_store_if.sv
`timescale 1ns/1ps
`default_nettype none
// write request into one port's stored bits, and the bits back
interface gdp_store_if;
   logic       wrEn;       // one-cycle store strobe
   logic [7:0] wrData;     // value to store
   logic [7:0] storedBits; // present stored bits
   // storage side
   modport store (input wrEn, input wrData, output storedBits);
   // decoder side
   modport ctrl (output wrEn, output wrData, input storedBits);
endinterface
`default_nettype wire

// ===== verif/gdp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side of one port: outside drivers, pull-ups and the pad wire
module gdp_pin_model #(
   parameter int unsigned W = 8
) (
   input  wire logic         clock,
   input  wire logic [W-1:0] pinOut,  // value the port offers
   input  wire logic [W-1:0] pinOe,   // port drives the pad while high
   input  wire logic [W-1:0] pullUp,  // pull-up enable per pad
   input  wire logic [W-1:0] extVal,  // outside device value
   input  wire logic [W-1:0] extEn,   // outside device drives while high
   output var  logic [W-1:0] pinLevel // resolved pad level
);
   logic floatBit = 1'b0; // changing level for a pad nobody holds

   // a floating pad never looks stable
   always_ff @(posedge clock) begin
      floatBit <= ~floatBit;
   end

   // resolve each pad from every party
   always_comb begin
      for (int n = 0; n < W; n++) begin
         if (pinOe[n]) begin
            pinLevel[n] = pinOut[n];
         end else if (extEn[n]) begin
            pinLevel[n] = extVal[n];
         end else if (pullUp[n]) begin
            pinLevel[n] = 1'b1;
         end else begin
            pinLevel[n] = floatBit;
         end
      end
   end
endmodule // gdp_pin_model
`default_nettype wire

// ===== verif/tb_gdp_data_ports.sv
`timescale 1ns/1ps
`default_nettype none
// bench for the data side of the three pin ports
module tb_gdp_data_ports;
   import gdp_pkg::*;
   logic              clock     = 1'b0;
   logic              reset_n   = 1'b0;
   logic [ADDR_W-1:0] regAddr   = '0;
   logic [DATA_W-1:0] regWrData = '0;
   logic              regWrite  = 1'b0;
   logic              regRead   = 1'b0;
   logic [DATA_W-1:0] regRdData;              // read return
   logic [2:0][15:0]  code      = {3{16'hAAAA}}; // pins start pulled-up inputs
   logic [2:0][7:0]   extVal    = '0;         // outside drive values
   logic [2:0][7:0]   extEn     = '0;         // outside drive enables
   wire  [2:0][7:0]   pOut, pOe, pPu, pLvl;   // pin views per port
   logic [15:0]       pats [6] = '{16'h0000, 16'h5555, 16'hAAAA, 16'hFFFF,
                                   16'h9999, 16'hE4E4}; // code mixes
   int                num_errors = 0;
   int                n_compared = 0;
   int                cycles     = 0;

   gdp_data_ports dut (
      .clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .portDFuncCode(code[0]), .portEFuncCode(code[1]), .portFFuncCode(code[2][13:0]),
      .portDPinIn(pLvl[0]), .portDPinOut(pOut[0]), .portDPinOe(pOe[0]),
      .portDPullUp(pPu[0]), .portEPinIn(pLvl[1]), .portEPinOut(pOut[1]),
      .portEPinOe(pOe[1]), .portEPullUp(pPu[1]), .portFPinIn(pLvl[2][6:0]),
      .portFPinOut(pOut[2][6:0]), .portFPinOe(pOe[2][6:0]), .portFPullUp(pPu[2][6:0])
   );
   gdp_pin_model #(.W(8)) padD (.clock(clock), .pinOut(pOut[0]), .pinOe(pOe[0]),
      .pullUp(pPu[0]), .extVal(extVal[0]), .extEn(extEn[0]), .pinLevel(pLvl[0]));
   gdp_pin_model #(.W(8)) padE (.clock(clock), .pinOut(pOut[1]), .pinOe(pOe[1]),
      .pullUp(pPu[1]), .extVal(extVal[1]), .extEn(extEn[1]), .pinLevel(pLvl[1]));
   gdp_pin_model #(.W(7)) padF (.clock(clock), .pinOut(pOut[2][6:0]),
      .pinOe(pOe[2][6:0]), .pullUp(pPu[2][6:0]), .extVal(extVal[2][6:0]),
      .extEn(extEn[2][6:0]), .pinLevel(pLvl[2][6:0]));
   // port F has no eighth pin; its views stay low
   assign {pOut[2][7], pOe[2][7], pPu[2][7], pLvl[2][7]} = 4'h0;

   // 8 ns clock
   always #4 clock = ~clock;

   // verdict and end of run
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         $display("[ERR] %0t run did not finish", $time);
         summarize();
      end
   end

   // compare one value and count it
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle write, entered just after an edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      regWrite  <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask

   // one-cycle read; data stands one cycle, then idles
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      @(negedge clock);
      check(regRdData, exp);
      @(negedge clock);
      check(regRdData, RD_IDLE);
      @(posedge clock);
   endtask

   // power-on reset held six cycles
   task automatic doReset();
      reset_n <= 1'b0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
   endtask

   function automatic logic [3:0] offOf(input int p);
      return (p == 0) ? OFF_PORT_D : (p == 1) ? OFF_PORT_E : OFF_PORT_F;
   endfunction

   // main sequence
   initial begin
      logic [7:0] wd, mask, lvl, rdv, oe, pu;
      logic [1:0] c;
      // power-on reset low for the first six rising edges
      repeat (5) @(posedge clock);
      @(negedge clock);
      check(pOe[0], RST_OE);
      check(pPu[1], RST_PULLUP);
      @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      repeat (3) @(posedge clock);
      rd(OFF_PORT_D, 8'hFF);
      rd(OFF_PORT_E, 8'hFF);
      rd(OFF_PORT_F, 8'h7F);
      code <= '0;
      repeat (4) @(posedge clock);
      rd(OFF_PORT_D, RST_PORT_D);
      rd(OFF_PORT_E, RST_PORT_E);
      rd(OFF_PORT_F, RST_PORT_F);
      // every code mix on every port
      for (int p = 0; p < 3; p++) begin
         for (int m = 0; m < 6; m++) begin
            mask = (p == 2) ? 8'h7F : 8'hFF;
            wd   = 8'h5A ^ {p[3:0], m[3:0]};
            for (int n = 0; n < 8; n++) begin
               c = pats[m][2*n+:2];
               extEn[p][n] <= (c == FUNC_OTHER) || (c == FUNC_IN_NOPU);
               oe[n]  = (c == FUNC_OUTPUT);
               pu[n]  = (c == FUNC_IN_PU);
               lvl[n] = oe[n] ? wd[n] : pu[n] ? 1'b1 : ~wd[n];
               rdv[n] = c[1] ? lvl[n] : wd[n];
            end
            extVal[p] <= ~wd;
            code[p]   <= pats[m];
            repeat (4) @(posedge clock);
            wr(offOf(p), wd);
            rd(offOf(p), rdv & mask);
            // pin views sampled mid-cycle, away from the launching edge
            @(negedge clock);
            check(pOe[p] & mask, oe & mask);
            check(pPu[p] & mask, pu & mask);
            check(pOut[p] & mask, wd & mask);
            check(pLvl[p] & mask, lvl & mask);
            @(posedge clock);
         end
      end
      // unmapped places ignore writes and read idle
      wr(4'h3, 8'hFF);
      rd(4'h3, RD_IDLE);
      rd(4'hF, RD_IDLE);
      code[0] <= '0;
      repeat (20) @(posedge clock);
      rd(OFF_PORT_D, 8'h5A ^ 8'h05);
      doReset();
      rd(OFF_PORT_D, RST_PORT_D);
      summarize();
   end
endmodule // tb_gdp_data_ports
`default_nettype wire
